/* include/ddc_cfg.svh */
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH

// Control word field positions, most significant first.
`define DDC_PWRDN_BIT     3'h7
`define DDC_EN_BIT        3'h6
`define DDC_ILV_BIT       3'h5
`define DDC_REF_BIT       3'h4
`define DDC_GAIN_MSB      3'h3
`define DDC_GAIN_LSB      3'h0

// Power-up word: converter on, internal reference, plain inputs, 0 dB trim.
`define DDC_CFG_RESET     8'h48

// Gain trim: code zero is +0.4 dB, each step is -0.05 dB.
`define DDC_GAIN_TOP_STEP 5'h08

// Wake-up from standby, in ns, and the clock period in ns.
`define DDC_WAKE_NS       3000
`define DDC_CLK_NS        5
`define DDC_WAKE_CYC      ((`DDC_WAKE_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)

`endif

/* include/ddc_pkg.sv */
package ddc_pkg;

    typedef enum logic [1:0] {
        DDC_NORMAL,
        DDC_STANDBY,
        DDC_POWERDOWN
    } ddc_mode_t;

endpackage : ddc_pkg

/* hdl/ddc_cfg_capture.sv */
`timescale 1ns/10ps
`include "ddc_cfg.svh"

module ddc_cfg_capture (
    input  wire logic       ref_clk,              // Conversion clock.
    input  wire logic       rst_sync_n,           // Synchronised reset.
    input  wire logic       config_write_strobe_n,// Async write strobe.
    input  wire logic [7:0] port_a,               // Word on port A.
    output logic      [7:0] cfg_word              // Held control word.
);

    logic [7:0] data_s1_ff;
    logic [7:0] data_s2_ff;
    logic       stb_s1_ff;
    logic       stb_s2_ff;
    logic       stb_s3_ff;
    logic [7:0] cfg_ff;

    // --------------------------------------------------------------
    // Strobe and data synchronisers
    // --------------------------------------------------------------
    // Both paths share the same delay, so the data seen at the
    // detected strobe edge is the word held around the pin edge.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stb_s1_ff  <= 1'b1;
            stb_s2_ff  <= 1'b1;
            stb_s3_ff  <= 1'b1;
            data_s1_ff <= 8'h00;
            data_s2_ff <= 8'h00;
        end else begin
            stb_s1_ff  <= config_write_strobe_n;
            stb_s2_ff  <= stb_s1_ff;
            stb_s3_ff  <= stb_s2_ff;
            data_s1_ff <= port_a;
            data_s2_ff <= data_s1_ff;
        end
    end

    // --------------------------------------------------------------
    // Word load on the strobe's rising edge
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_ff <= `DDC_CFG_RESET;
        end else if (stb_s2_ff && !stb_s3_ff) begin
            cfg_ff <= data_s2_ff;
        end
    end

    assign cfg_word = cfg_ff;

endmodule : ddc_cfg_capture

/* hdl/ddc_dac_front.sv */
`timescale 1ns/10ps
`include "ddc_cfg.svh"

// Operation
// - Capture on rising edge, output next edge.
// - Control word arrives on port A.
// - Load word on strobe rising edge.
// - Strobe is asynchronous; clock may keep running.
// - Bits: powerdown, enable, interleave, reference, gain.
// - Powerdown bit set forces power-down.
// - Enable low without powerdown means standby.
// - Outputs invalid for 3 us after wake.
// - Interleave bit multiplexes both channels on A.
// - B on falling edge, A on rising.
// - Reference bit selects internal or external.
// - Gain trim affects channel A only.
// - Trim steps 0.05 dB, +0.4 to -0.35.
// - Power-up defaults: internal, plain, 0 dB, on.
// - Interleaved pair updates both outputs together.
// - Interleaved per-channel rate is halved.
module ddc_dac_front #(
    parameter int WAKE_CYC = `DDC_WAKE_CYC  // Wake-up length in cycles.
) (
    input  wire logic            ref_clk,      // 200 MHz conversion clock.
    input  wire logic            rst_n,        // Async reset, active low.
    input  wire logic [7:0]      port_a,       // Channel A sample / config.
    input  wire logic [7:0]      port_b,       // Channel B sample.
    input  wire logic            config_write_strobe_n, // Config strobe.
    output logic      [7:0]      dac_a_code,   // Code driving channel A.
    output logic      [7:0]      dac_b_code,   // Code driving channel B.
    output logic                 out_update,   // Pulse: outputs updated.
    output logic                 out_valid,    // Conversion output valid.
    output ddc_pkg::ddc_mode_t   power_mode,   // Current power mode.
    output logic                 interleave_on,// Interleaved input mode.
    output logic                 ref_external, // Internal reference off.
    output logic      [3:0]      gain_trim_a,  // Channel A trim code.
    output logic signed [4:0]    gain_a_step   // A gain in 0.05 dB steps.
);

    logic       rst_s1_ff;
    logic       rst_s2_ff;
    logic [7:0] cfg_word;

    // --------------------------------------------------------------
    // Reset release
    // --------------------------------------------------------------
    // Assertion is immediate; release passes two flops so that the
    // internal reset never ends close to a clock edge.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    ddc_cfg_capture u_cfg (
        .ref_clk               (ref_clk),
        .rst_sync_n            (rst_s2_ff),
        .config_write_strobe_n (config_write_strobe_n),
        .port_a                (port_a),
        .cfg_word              (cfg_word)
    );

    // --------------------------------------------------------------
    // Control word decode
    // --------------------------------------------------------------
    logic       powerdown_bit;
    logic       converter_enable_bit;
    logic       interleave_select_bit;
    logic       ref_disable_bit;
    logic [3:0] gain_code;
    ddc_pkg::ddc_mode_t nxt_mode;

    assign powerdown_bit         = cfg_word[`DDC_PWRDN_BIT];
    assign converter_enable_bit  = cfg_word[`DDC_EN_BIT];
    assign interleave_select_bit = cfg_word[`DDC_ILV_BIT];
    assign ref_disable_bit       = cfg_word[`DDC_REF_BIT];
    assign gain_code = cfg_word[`DDC_GAIN_MSB:`DDC_GAIN_LSB];

    always_comb begin
        if (powerdown_bit) begin
            nxt_mode = ddc_pkg::DDC_POWERDOWN;
        end else if (!converter_enable_bit) begin
            nxt_mode = ddc_pkg::DDC_STANDBY;
        end else begin
            nxt_mode = ddc_pkg::DDC_NORMAL;
        end
    end

    // Gain of channel A relative to B, in 0.05 dB units.
    function automatic logic signed [4:0] trim_to_step(
        input logic [3:0] code
    );
        trim_to_step = $signed(`DDC_GAIN_TOP_STEP - {1'b0, code});
    endfunction : trim_to_step

    ddc_pkg::ddc_mode_t mode_ff;
    logic               intl_ff;
    logic               ref_ext_ff;
    logic [3:0]         gain_ff;
    logic signed [4:0]  gstep_ff;

    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            mode_ff    <= ddc_pkg::DDC_NORMAL;
            intl_ff    <= 1'b0;
            ref_ext_ff <= 1'b0;
            gain_ff    <= 4'h8;
            gstep_ff   <= 5'sh00;
        end else begin
            mode_ff    <= nxt_mode;
            intl_ff    <= interleave_select_bit;
            ref_ext_ff <= ref_disable_bit;
            gain_ff    <= gain_code;
            gstep_ff   <= trim_to_step(gain_code);
        end
    end

    // --------------------------------------------------------------
    // Wake-up timer
    // --------------------------------------------------------------
    logic [15:0] wake_cnt_ff;
    logic        valid_ff;

    // The count restarts whenever the decoded mode leaves normal, so
    // every wake-up waits out the full interval before outputs count.
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            wake_cnt_ff <= 16'h0000;
            valid_ff    <= 1'b1;
        end else if (nxt_mode != ddc_pkg::DDC_NORMAL) begin
            wake_cnt_ff <= 16'h0000;
            valid_ff    <= 1'b0;
        end else if (!valid_ff) begin
            if (wake_cnt_ff == 16'(WAKE_CYC - 1)) begin
                valid_ff <= 1'b1;
            end else begin
                wake_cnt_ff <= wake_cnt_ff + 16'h0001;
            end
        end
    end

    // --------------------------------------------------------------
    // Sample path
    // --------------------------------------------------------------
    logic [7:0] b_fall_ff;
    logic [7:0] cap_a_ff;
    logic [7:0] cap_b_ff;
    logic       cap_new_ff;
    logic       pair_phase_ff;
    logic [7:0] out_a_ff;
    logic [7:0] out_b_ff;
    logic       upd_ff;

    // Port A is taken on every falling edge; the value is only used
    // as channel B when a pair is captured in interleaved mode.
    always_ff @(negedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            b_fall_ff <= 8'h00;
        end else begin
            b_fall_ff <= port_a;
        end
    end

    // Phase zero marks the rising edge that takes a pair; the edge
    // between is skipped, which halves the rate of each channel.
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            pair_phase_ff <= 1'b0;
        end else begin
            pair_phase_ff <= intl_ff ? !pair_phase_ff : 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            cap_a_ff   <= 8'h00;
            cap_b_ff   <= 8'h00;
            cap_new_ff <= 1'b0;
        end else if (mode_ff != ddc_pkg::DDC_NORMAL) begin
            cap_new_ff <= 1'b0;
        end else if (!intl_ff) begin
            cap_a_ff   <= port_a;
            cap_b_ff   <= port_b;
            cap_new_ff <= 1'b1;
        end else if (!pair_phase_ff) begin
            cap_a_ff   <= port_a;
            cap_b_ff   <= b_fall_ff;
            cap_new_ff <= 1'b1;
        end else begin
            cap_new_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            out_a_ff <= 8'h00;
            out_b_ff <= 8'h00;
            upd_ff   <= 1'b0;
        end else begin
            upd_ff <= cap_new_ff;
            if (cap_new_ff) begin
                out_a_ff <= cap_a_ff;
                out_b_ff <= cap_b_ff;
            end
        end
    end

    assign dac_a_code    = out_a_ff;
    assign dac_b_code    = out_b_ff;
    assign out_update    = upd_ff;
    assign out_valid     = valid_ff;
    assign power_mode    = mode_ff;
    assign interleave_on = intl_ff;
    assign ref_external  = ref_ext_ff;
    assign gain_trim_a   = gain_ff;
    assign gain_a_step   = gstep_ff;

endmodule : ddc_dac_front

/* testbench/ddc_checker.sv */
`timescale 1ns/10ps
module ddc_checker #(
    parameter int WAKE_CYC = 8 // Wake-up cycles.
) (
    input wire logic               ref_clk,      // Clock.
    input wire logic               rst_n,        // Reset.
    input wire logic [7:0]         port_a,       // Data A.
    input wire logic [7:0]         port_b,       // Data B.
    input wire logic               config_write_strobe_n, // Strobe.
    input wire logic [7:0]         dac_a_code,   // Code A.
    input wire logic [7:0]         dac_b_code,   // Code B.
    input wire logic               out_update,   // Update.
    input wire logic               out_valid,    // Valid.
    input wire ddc_pkg::ddc_mode_t power_mode,   // Mode.
    input wire logic               interleave_on,// Interleave.
    input wire logic               ref_external, // Reference.
    input wire logic [3:0]         gain_trim_a,  // Trim.
    input wire logic signed [4:0]  gain_a_step   // Gain.
);
    logic [15:0] wake_ff;
    wire         normal = power_mode == ddc_pkg::DDC_NORMAL;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Counts cycles spent in normal mode before the output is valid.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) wake_ff <= 16'h0000;
        else if (normal && !out_valid) wake_ff <= wake_ff + 16'h0001;
        else wake_ff <= 16'h0000;
    end
    chk_plain_codes: assert property (
        out_update && !interleave_on && !$past(interleave_on, 2) |->
        dac_a_code == $past(port_a, 2) && dac_b_code == $past(port_b, 2))
        else $error("plain codes differ");
    chk_idle_hold: assert property (
        !normal [*3] |-> !out_update && $stable(dac_a_code))
        else $error("update while idle");
    chk_gain_map: assert property (
        $stable(gain_trim_a) |->
        gain_a_step == 5'sh08 - $signed({1'b0, gain_trim_a}))
        else $error("gain step wrong");
    chk_valid_mode: assert property (
        !normal |=> !out_valid)
        else $error("valid outside normal");
    chk_wake_len: assert property (
        normal && $rose(out_valid) |->
        wake_ff >= WAKE_CYC - 1 && wake_ff <= WAKE_CYC + 1)
        else $error("wake length wrong");
    chk_wake_bound: assert property (
        wake_ff <= WAKE_CYC + 2)
        else $error("wake too long");
    chk_cfg_hold: assert property (
        config_write_strobe_n [*8] |-> $stable({interleave_on,
        ref_external, gain_trim_a, power_mode}))
        else $error("config changed");
    chk_ilv_space: assert property (
        interleave_on && $past(interleave_on, 2) && out_update |=>
        !out_update)
        else $error("pairs too close");
    chk_ilv_a: assert property (
        out_update && interleave_on && $past(interleave_on, 2) |->
        dac_a_code == $past(port_a, 2))
        else $error("interleaved A wrong");
endmodule : ddc_checker

bind ddc_dac_front ddc_checker #(.WAKE_CYC(WAKE_CYC)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .port_a(port_a), .port_b(port_b),
    .config_write_strobe_n(config_write_strobe_n),
    .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
    .out_update(out_update), .out_valid(out_valid),
    .power_mode(power_mode), .interleave_on(interleave_on),
    .ref_external(ref_external), .gain_trim_a(gain_trim_a),
    .gain_a_step(gain_a_step));

/* testbench/ddc_host_model.sv */
`timescale 1ns/10ps
module ddc_host_model (
    input  wire logic       ref_clk,              // Clock.
    output logic      [7:0] port_a,               // Data A.
    output logic      [7:0] port_b,               // Data B.
    output logic            config_write_strobe_n // Strobe.
);
    initial begin
        port_a = 8'h00;
        port_b = 8'h00;
        config_write_strobe_n = 1'b1;
    end
    // Word is held around the strobe rise, then replaced by its inverse.
    task automatic write_cfg(input logic [7:0] w);
        @(negedge ref_clk);
        port_a = w;
        config_write_strobe_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        config_write_strobe_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        port_a = ~w;
        repeat (6) @(negedge ref_clk);
    endtask : write_cfg
    task automatic send(input logic [7:0] a, input logic [7:0] b);
        @(negedge ref_clk);
        port_a = a;
        port_b = b;
    endtask : send
    // Repeated so that either internal phase takes a correct pair.
    task automatic send_ilv(input logic [7:0] a, input logic [7:0] b);
        repeat (2) begin
            @(posedge ref_clk);
            port_a <= b;
            @(negedge ref_clk);
            port_a <= a;
        end
    endtask : send_ilv
endmodule : ddc_host_model

/* testbench/ddc_dac_front_tb_top.sv */
`timescale 1ns/10ps
module ddc_dac_front_tb_top;
    localparam int WAKE = 8;
    logic ref_clk, rst_n, config_write_strobe_n, out_update, out_valid;
    logic [7:0] port_a, port_b, dac_a_code, dac_b_code;
    logic interleave_on, ref_external;
    ddc_pkg::ddc_mode_t power_mode;
    logic [3:0] gain_trim_a;
    logic signed [4:0] gain_a_step;
    logic [7:0] cfg_tab [6] = '{8'h00, 8'h80, 8'hC0, 8'h5F, 8'h40, 8'h68};
    int errors, tests_run, n;
    ddc_host_model u_host (.ref_clk(ref_clk), .port_a(port_a),
        .port_b(port_b), .config_write_strobe_n(config_write_strobe_n));
    ddc_dac_front #(.WAKE_CYC(WAKE)) u_dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .port_a(port_a), .port_b(port_b),
        .config_write_strobe_n(config_write_strobe_n),
        .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
        .out_update(out_update), .out_valid(out_valid),
        .power_mode(power_mode), .interleave_on(interleave_on),
        .ref_external(ref_external), .gain_trim_a(gain_trim_a),
        .gain_a_step(gain_a_step));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_code
    task automatic complete_run;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task automatic wait_update;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (out_update !== 1'b1 && n < 40);
        if (out_update !== 1'b1) begin
            errors++;
            complete_run();
        end
    endtask : wait_update
    task automatic chk_cfg(input logic [7:0] w);
        ddc_pkg::ddc_mode_t m;
        m = w[7] ? ddc_pkg::DDC_POWERDOWN
          : (w[6] ? ddc_pkg::DDC_NORMAL : ddc_pkg::DDC_STANDBY);
        u_host.write_cfg(w);
        chk_code({6'h00, power_mode}, {6'h00, m});
        chk_code({7'h00, interleave_on}, {7'h00, w[5]});
        chk_code({7'h00, ref_external}, {7'h00, w[4]});
        chk_code({4'h0, gain_trim_a}, {4'h0, w[3:0]});
        chk_code({3'h0, gain_a_step},
                 {3'h0, 5'h08 - {1'b0, w[3:0]}});
    endtask : chk_cfg
    initial begin
        errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk_code({6'h00, power_mode}, {6'h00, ddc_pkg::DDC_NORMAL});
        chk_code({out_valid, interleave_on, ref_external, gain_trim_a,
                  1'b0}, 8'h90);
        for (int i = 0; i < 5; i++) begin
            if (i < 3) u_host.send(8'h35 ^ 8'(i), 8'hC0 | 8'(i));
            else @(negedge ref_clk);
            if (i >= 2) begin
                chk_code(dac_a_code, 8'h35 ^ 8'(i - 2));
                chk_code(dac_b_code, 8'hC0 | 8'(i - 2));
                chk_code({7'h00, out_update}, 8'h01);
            end
        end
        foreach (cfg_tab[j]) begin
            chk_cfg(cfg_tab[j]);
            if (cfg_tab[j] == 8'h00) u_host.send(8'hAA, 8'h55);
            if (!cfg_tab[j][6] || cfg_tab[j][7]) begin
                repeat (3) @(negedge ref_clk);
                chk_code(dac_b_code, 8'hC2);
            end
            if (cfg_tab[j] == 8'h5F) begin
                chk_code({7'h00, out_valid}, 8'h00);
                repeat (WAKE + 4) @(negedge ref_clk);
                chk_code({7'h00, out_valid}, 8'h01);
            end
        end
        u_host.send_ilv(8'h5A, 8'hA5);
        wait_update();
        chk_code(dac_a_code, 8'h5A);
        chk_code(dac_b_code, 8'hA5);
        complete_run();
    end
endmodule : ddc_dac_front_tb_top
